// [core/rrf_defs.svh]
`ifndef RRF_DEFS_SVH
`define RRF_DEFS_SVH

// ----------------------------------------------------------------
// Zero-run detection
// ----------------------------------------------------------------
// Zeros in a row that make an excess-zero event
`define RRF_EXZ_LIMIT      4'h3
`define RRF_ZERO_CNT_RST   4'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RRF_RAIL_RST       1'b0
`define RRF_TGL_RST        1'b0
`define RRF_SYNC_RST       2'h0
`define RRF_LINK_RST_ON    2'h3
`define RRF_COUNT_RST      16'h0000
`define RRF_COUNT_MAX      16'hffff
`define RRF_COUNT_ONE      16'h0001

`endif

// [core/rrf_pkg.sv]
package rrf_pkg;

    // ----------------------------------------------------------------
    // Shared types
    // ----------------------------------------------------------------
    typedef enum logic {
        RRF_DUAL_RAIL   = 1'b0,
        RRF_SINGLE_RAIL = 1'b1
    } rrf_mode_t;

    typedef enum logic {
        RRF_EDGE_RISE = 1'b0,
        RRF_EDGE_FALL = 1'b1
    } rrf_edge_t;

    // Sliced line pulses, one bit per polarity
    typedef struct packed {
        logic pos;
        logic neg;
    } rrf_rails_t;

    // Saturating event counts in the reference domain
    typedef struct packed {
        logic [15:0] code_violation;
        logic [15:0] excess_zero;
    } rrf_counts_t;

endpackage

// [core/rrf_rx_rail_output_formatter.sv]
// Operation
// - Dual rail: negative output high one clock per negative line pulse.
// - Dual rail: positive pulses to positive output, negative to negative.
// - Single rail: negative output becomes the code violation indicator.
// - Single rail: indicator high at least one clock on violation or zeros.
// - Negative/violation output updates only on the selected clock edge.
// - Recovered clock driven out; both rails change on its selected edge.
// - Single rail: all recovered data bits leave on the positive output.
`timescale 1ns/100ps
`include "rrf_defs.svh"

module rrf_rx_rail_output_formatter (
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic                rec_clk_in,
    input  wire rrf_pkg::rrf_rails_t line_input_pair_in,
    input  wire logic                single_rail_in,
    input  wire logic                fall_edge_sel_in,
    output wire logic                recovered_clock_out,
    output wire logic                rx_pos_rail_out,
    output wire logic                rx_neg_rail_out,
    output wire logic                code_violation_flag_out,
    output wire logic                excess_zero_event_out,
    output wire rrf_pkg::rrf_counts_t event_counts_out
);
    import rrf_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] sat_inc(input logic [15:0] value);
        sat_inc = (value == `RRF_COUNT_MAX) ? value
                                            : value + `RRF_COUNT_ONE;
    endfunction

    function automatic logic [3:0] zero_step(input logic [3:0] value,
                                             input logic       pulse);
        if (pulse) begin
            zero_step = `RRF_ZERO_CNT_RST;
        end else if (value == `RRF_EXZ_LIMIT) begin
            zero_step = value;
        end else begin
            zero_step = value + 4'h1;
        end
    endfunction

    // ----------------------------------------------------------------
    // Link-domain reset
    // ----------------------------------------------------------------
    // Asserted at once, released on the recovered clock
    logic [1:0] link_rst_pipe_r;
    wire logic  link_rst;

    always_ff @(posedge rec_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_rst_pipe_r <= `RRF_LINK_RST_ON;
        end else begin
            link_rst_pipe_r <= {link_rst_pipe_r[0], 1'b0};
        end
    end

    assign link_rst = link_rst_pipe_r[1];

    // ----------------------------------------------------------------
    // Setting pins into the link domain
    // ----------------------------------------------------------------
    logic [1:0] mode_sync_r;
    logic [1:0] edge_sync_r;
    rrf_mode_t  mode;
    rrf_edge_t  edge_sel;

    always_ff @(posedge rec_clk_in or posedge link_rst) begin
        if (link_rst) begin
            mode_sync_r <= `RRF_SYNC_RST;
            edge_sync_r <= `RRF_SYNC_RST;
        end else begin
            mode_sync_r <= {mode_sync_r[0], single_rail_in};
            edge_sync_r <= {edge_sync_r[0], fall_edge_sel_in};
        end
    end

    assign mode     = rrf_mode_t'(mode_sync_r[1]);
    assign edge_sel = rrf_edge_t'(edge_sync_r[1]);

    // ----------------------------------------------------------------
    // Line checking
    // ----------------------------------------------------------------
    // Line pulses come from the slicer on this same clock
    wire logic pos_pulse;
    wire logic neg_pulse;
    wire logic any_pulse;

    logic       last_neg_r;
    logic       seen_pulse_r;
    logic [3:0] zero_cnt_r;
    logic [3:0] zero_cnt_nxt;

    assign pos_pulse = line_input_pair_in.pos;
    assign neg_pulse = line_input_pair_in.neg;
    assign any_pulse = pos_pulse | neg_pulse;

    // Same polarity twice running, or both polarities at once
    wire logic bipolar_violation;
    assign bipolar_violation = (pos_pulse & neg_pulse)
        | (pos_pulse & seen_pulse_r & ~last_neg_r)
        | (neg_pulse & seen_pulse_r &  last_neg_r);

    // One event when the zero run first reaches the limit
    wire logic excess_zero_event;
    assign zero_cnt_nxt      = zero_step(zero_cnt_r, any_pulse);
    assign excess_zero_event = ~any_pulse
        & (zero_cnt_r != `RRF_EXZ_LIMIT)
        & (zero_cnt_nxt == `RRF_EXZ_LIMIT);

    always_ff @(posedge rec_clk_in or posedge link_rst) begin
        if (link_rst) begin
            last_neg_r   <= 1'b0;
            seen_pulse_r <= 1'b0;
            zero_cnt_r   <= `RRF_ZERO_CNT_RST;
        end else begin
            if (any_pulse) begin
                last_neg_r   <= neg_pulse;
                seen_pulse_r <= 1'b1;
            end
            zero_cnt_r <= zero_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Rail selection
    // ----------------------------------------------------------------
    logic pos_rail_r;
    logic neg_rail_r;
    wire logic pos_rail_nxt;
    wire logic neg_rail_nxt;
    wire logic code_violation_flag;

    assign code_violation_flag = bipolar_violation | excess_zero_event;

    assign pos_rail_nxt = (mode == RRF_SINGLE_RAIL) ? any_pulse : pos_pulse;

    assign neg_rail_nxt = (mode == RRF_SINGLE_RAIL) ? code_violation_flag
                                                    : neg_pulse;

    always_ff @(posedge rec_clk_in or posedge link_rst) begin
        if (link_rst) begin
            pos_rail_r <= `RRF_RAIL_RST;
            neg_rail_r <= `RRF_RAIL_RST;
        end else begin
            pos_rail_r <= pos_rail_nxt;
            neg_rail_r <= neg_rail_nxt;
        end
    end

    assign rx_pos_rail_out         = pos_rail_r;
    assign rx_neg_rail_out         = neg_rail_r;

    // ----------------------------------------------------------------
    // Clock out
    // ----------------------------------------------------------------
    // Inverting the driven clock puts the update on its falling edge
    // while all flops stay on one edge. Limitation: a change of the
    // setting can give one short clock phase at the pin.
    // edge choice
    assign recovered_clock_out = rec_clk_in ^ (edge_sel == RRF_EDGE_FALL);

    // ----------------------------------------------------------------
    // Events toward the reference domain
    // ----------------------------------------------------------------
    // Toggles, since a level pulse could be missed or doubled when
    // sampled across unrelated clocks
    logic viol_tgl_r;
    logic exz_tgl_r;

    always_ff @(posedge rec_clk_in or posedge link_rst) begin
        if (link_rst) begin
            viol_tgl_r <= `RRF_TGL_RST;
            exz_tgl_r  <= `RRF_TGL_RST;
        end else begin
            if (bipolar_violation) begin
                viol_tgl_r <= ~viol_tgl_r;
            end
            if (excess_zero_event) begin
                exz_tgl_r <= ~exz_tgl_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reference domain
    // ----------------------------------------------------------------
    logic [1:0]  viol_sync_r;
    logic [1:0]  exz_sync_r;
    logic        viol_prev_r;
    logic        exz_prev_r;
    logic        viol_evt_r;
    logic        exz_evt_r;
    logic [15:0] viol_cnt_r;
    logic [15:0] exz_cnt_r;
    wire logic   viol_seen;
    wire logic   exz_seen;

    assign viol_seen = viol_sync_r[1] ^ viol_prev_r;
    assign exz_seen  = exz_sync_r[1] ^ exz_prev_r;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            viol_sync_r <= `RRF_SYNC_RST;
            exz_sync_r  <= `RRF_SYNC_RST;
            viol_prev_r <= `RRF_TGL_RST;
            exz_prev_r  <= `RRF_TGL_RST;
        end else begin
            viol_sync_r <= {viol_sync_r[0], viol_tgl_r};
            exz_sync_r  <= {exz_sync_r[0], exz_tgl_r};
            viol_prev_r <= viol_sync_r[1];
            exz_prev_r  <= exz_sync_r[1];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            viol_evt_r <= 1'b0;
            exz_evt_r  <= 1'b0;
        end else begin
            viol_evt_r <= viol_seen;
            exz_evt_r  <= exz_seen;
        end
    end

    // Counts stick at full scale rather than wrap
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            viol_cnt_r <= `RRF_COUNT_RST;
            exz_cnt_r  <= `RRF_COUNT_RST;
        end else begin
            if (viol_seen) begin
                viol_cnt_r <= sat_inc(viol_cnt_r);
            end
            if (exz_seen) begin
                exz_cnt_r <= sat_inc(exz_cnt_r);
            end
        end
    end

    assign code_violation_flag_out         = viol_evt_r;
    assign excess_zero_event_out           = exz_evt_r;
    assign event_counts_out.code_violation = viol_cnt_r;
    assign event_counts_out.excess_zero    = exz_cnt_r;

endmodule // rrf_rx_rail_output_formatter

// [test/rrf_far_framer.sv]
`timescale 1ns/100ps
module rrf_far_framer (
    input  wire logic clk_out_in,
    input  wire logic fall_sel_in,
    input  wire logic pos_in,
    input  wire logic neg_in,
    output logic      pos_smp_out,
    output logic      neg_smp_out
);
    always @(clk_out_in) begin
        if (clk_out_in === fall_sel_in) begin
            pos_smp_out <= pos_in;
            neg_smp_out <= neg_in;
        end
    end
endmodule // rrf_far_framer

// [test/rrf_chk.sv]
`timescale 1ns/100ps
module rrf_chk (
    input logic                ref_clk_in,
    input logic                rst_in,
    input logic                rec_clk_in,
    input rrf_pkg::rrf_rails_t line_input_pair_in,
    input logic                single_rail_in,
    input logic                fall_edge_sel_in,
    input logic                recovered_clock_out,
    input logic                rx_pos_rail_out,
    input logic                rx_neg_rail_out
);
    import rrf_pkg::*;
    // Pins pass two sync flops, so judge only after they settle
    logic [5:0] run_r;
    logic [3:0] md_r, ed_r;
    always_ff @(posedge rec_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_r <= 6'h00;
            md_r  <= 4'h0;
            ed_r  <= 4'h0;
        end else begin
            run_r <= {run_r[4:0], 1'b1};
            md_r  <= {md_r[2:0], single_rail_in};
            ed_r  <= {ed_r[2:0], fall_edge_sel_in};
        end
    end
    wire logic       dual = run_r[5] && md_r == 4'h0 && !single_rail_in;
    wire logic       sngl = run_r[5] && md_r == 4'hf && single_rail_in;
    wire logic [1:0] ln   = line_input_pair_in;
    wire logic       p_o  = rx_pos_rail_out;
    wire logic       n_o  = rx_neg_rail_out;
    property pr(a, b);
        @(posedge rec_clk_in) disable iff (rst_in) a |-> b;
    endproperty
    a_dual_neg: assert property (pr(dual, n_o == $past(ln[0])))
        else $error("neg rail not the delayed neg pulse");
    a_dual_pos: assert property (pr(dual, p_o == $past(ln[1])))
        else $error("pos rail not the delayed pos pulse");
    a_single_data: assert property (pr(sngl, p_o == $past(|ln)))
        else $error("single rail data wrong");
    a_single_both: assert property (pr(sngl && $past(&ln), n_o))
        else $error("both polarities not flagged");
    a_single_quiet: assert property (pr(sngl && $past(ln) == 2'h0
        && $past(ln, 2) != 2'h0, !n_o)) else $error("spurious flag");
    a_excess_zero: assert property (pr(sngl && $past(ln, 4) != 2'h0
        && {$past(ln, 3), $past(ln, 2), $past(ln)} == 6'h00, n_o))
        else $error("third zero not flagged");
    a_clock_follow: assert property (pr(run_r[5]
        && ed_r == {4{fall_edge_sel_in}},
        recovered_clock_out == fall_edge_sel_in))
        else $error("clock out polarity wrong");
    a_rec_edge: assert property (@(posedge ref_clk_in)
        disable iff (rst_in) !$stable({p_o, n_o}) |-> $rose(rec_clk_in))
        else $error("rail changed off the link edge");
    c_dual_neg: cover property (@(posedge rec_clk_in) dual && n_o);
    c_flag: cover property (@(posedge rec_clk_in) sngl && n_o);
    c_fall: cover property (@(posedge rec_clk_in) run_r[5] && ed_r == 4'hf);
endmodule // rrf_chk

bind rrf_rx_rail_output_formatter rrf_chk rrf_chk_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rec_clk_in(rec_clk_in),
    .line_input_pair_in(line_input_pair_in),
    .single_rail_in(single_rail_in), .fall_edge_sel_in(fall_edge_sel_in),
    .recovered_clock_out(recovered_clock_out),
    .rx_pos_rail_out(rx_pos_rail_out), .rx_neg_rail_out(rx_neg_rail_out)
);

// [test/rrf_rx_rail_output_formatter_tb.sv]
`timescale 1ns/100ps
module rrf_rx_rail_output_formatter_tb;
    import rrf_pkg::*;
    logic       ref_clk_in = 1'b0;
    logic       rec_clk_in = 1'b0;
    logic       rst_in     = 1'b1;
    rrf_rails_t line_in    = 2'h0;
    logic       single_in  = 1'b0;
    logic       fall_in    = 1'b0;
    logic       clk_o, pos_o, neg_o, pos_s, neg_s;
    logic       viol_o, exz_o;
    rrf_counts_t cnt_o;
    logic [15:0] viol_n     = 16'h0000;
    logic [15:0] exz_n      = 16'h0000;
    int         fail_count = 0;
    int         cmp_count  = 0;

    always #5 ref_clk_in = ~ref_clk_in;
    always #62.5 rec_clk_in = ~rec_clk_in;

    rrf_rx_rail_output_formatter rrf_rx_rail_output_formatter_inst (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rec_clk_in(rec_clk_in),
        .line_input_pair_in(line_in), .single_rail_in(single_in),
        .fall_edge_sel_in(fall_in), .recovered_clock_out(clk_o),
        .rx_pos_rail_out(pos_o), .rx_neg_rail_out(neg_o),
        .code_violation_flag_out(viol_o), .excess_zero_event_out(exz_o),
        .event_counts_out(cnt_o)
    );
    rrf_far_framer rrf_far_framer_inst (
        .clk_out_in(clk_o), .fall_sel_in(fall_in), .pos_in(pos_o),
        .neg_in(neg_o), .pos_smp_out(pos_s), .neg_smp_out(neg_s)
    );

    task automatic chk(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    task automatic chk16(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Flag pulses counted mid-cycle, clear of their launching edge
    always @(negedge ref_clk_in) begin
        if (viol_o === 1'b1) begin
            viol_n <= viol_n + 16'h0001;
        end
        if (exz_o === 1'b1) begin
            exz_n <= exz_n + 16'h0001;
        end
    end

    // Pins go through sync flops, so let them settle before traffic
    task automatic setm(input logic sr, input logic fe);
        @(posedge rec_clk_in);
        single_in <= sr;
        fall_in   <= fe;
        repeat (6) @(posedge rec_clk_in);
        #1;
        chk("clk_out", ~fe, clk_o);
    endtask

    // Six back-to-back line symbols; framer sample lags the drive by two edges
    task automatic run(input logic [11:0] v, input logic [5:0] ep, en);
        for (int i = 0; i < 8; i++) begin
            @(posedge rec_clk_in);
            line_in <= (i < 6) ? v[11 - 2 * i -: 2] : 2'h0;
            if (i >= 2) begin
                chk("rx_pos", ep[7 - i], pos_s);
                chk("rx_neg", en[7 - i], neg_s);
            end
        end
    endtask

    task automatic t_dual_rise();
        setm(1'b0, 1'b0);
        run(12'h5b2, 6'h0d, 6'h34);
    endtask

    // Last pulse before is positive, so the first one here repeats it
    task automatic t_single();
        setm(1'b1, 1'b0);
        run(12'h901, 6'h31, 6'h23);
    endtask

    task automatic t_dual_fall();
        setm(1'b0, 1'b1);
        run(12'h5b2, 6'h0d, 6'h34);
    endtask

    // Still single rail: both polarities at once, then a repeated pulse
    task automatic t_single_both();
        run(12'he84, 6'h3a, 6'h28);
    endtask

    // Nine violations and five zero runs since reset, the last one
    // closed by the idle edges here
    task automatic t_counts();
        repeat (4) @(posedge rec_clk_in);
        chk16("viol_count", 16'h0009, cnt_o.code_violation);
        chk16("exz_count", 16'h0005, cnt_o.excess_zero);
        chk16("viol_pulses", 16'h0009, viol_n);
        chk16("exz_pulses", 16'h0005, exz_n);
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        @(posedge rec_clk_in);
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_dual_rise();
        t_single();
        t_single_both();
        t_dual_fall();
        t_counts();
        wrap_up();
    end

    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule // rrf_rx_rail_output_formatter_tb
